// File: sfs_frame_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - super-frame is 12 frames, each one framing bit plus 24 8-bit channels
// - T1 searches framing bits of 12 frames for sequence 100011011100
// - J1 searches for 10001101110X, twelfth bit carries yellow alarm
// - T1 requires the frame 12 framing bit to be zero
// - the sequence found off the framing bit positions is a mimic
// - mimic check on: two clean sequences and no mimic give sync
// - mimic check off: two clean sequences give sync, mimics ignored
// - mimic seen flag sets on a mimic at the one probed bit slot per search pass
// - out of frame status is zero in sync, one otherwise
// - multiframe start marks the first bit of every super-frame while in sync
// - bit 8 of channels is signaling A in frame 6, B in 12
// - bypass passes received data with no frame processing
// - once aligned, keep checking framing bits and report errors
// - out of frame events follow software selected loss criteria
// - digital multiplexer and SLC-96 formats never offered for J1
module sfs_frame_sync
    import sfs_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic rx_bit_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    input wire logic j1_mode_in,
    input wire logic mimic_check_select_in,
    input wire logic framer_bypass_in,
    input wire logic [1:0] oof_criteria_in,
    input wire logic mimic_clear_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output sfs_word_s out_word_out,
    output logic out_of_frame_status_out,
    output logic mimic_seen_flag_out,
    output logic framing_error_out,
    output logic oof_event_out
);

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        sfs_state_e st;
        logic [7:0] bit_cnt;
        logic [3:0] frame;
        logic [11:0] fsr;
        logic [4:0] hcnt;
        logic [11:0] msr;
        logic [3:0] mcnt;
        logic [7:0] mpos;
        logic mimic_hit;
        logic [5:0] errs;
        logic mimic_flag;
        logic oof;
        logic ferr;
        logic oof_ev;
    } sfs_core_s;

    sfs_core_s r_ff;
    sfs_core_s nxt_r;
    sfs_word_s word;
    logic take;
    logic fifo_in_ready;
    logic is_f;
    logic slip;
    logic mimic_now;
    logic bad;
    logic [3:0] nf;
    logic [3:0] cur_frame;
    logic [11:0] new_fsr;
    logic [11:0] new_msr;
    logic [5:0] new_errs;
    logic [5:0] win;

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic fas_match(input logic [11:0] seq,
                                       input logic j1);
        logic [11:0] mask;
        mask = j1 ? SFS_J1_MASK : SFS_T1_MASK;
        return ((seq ^ SFS_ALIGN_SEQ) & mask) == 12'h000;
    endfunction

    function automatic logic fbit_ok(input logic b,
                                     input logic [3:0] frame,
                                     input logic j1);
        logic [3:0] idx;
        idx = SFS_LAST_FRAME - frame;
        // yellow alarm position is free in J1 only
        if (j1 && frame == SFS_LAST_FRAME) begin
            return 1'b1;
        end
        return b == SFS_ALIGN_SEQ[idx];
    endfunction

    function automatic logic [2:0] ones6(input logic [5:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 6; i++) begin
            c = c + {2'h0, v[i]};
        end
        return c;
    endfunction

    function automatic logic [3:0] next_frame(input logic [3:0] f);
        return (f == SFS_LAST_FRAME) ? SFS_FIRST_FRAME : f + SFS_ONE_FRAME;
    endfunction

    // ***********************************
    // loss window select
    // ***********************************
    always_comb begin
        unique case (oof_criteria_in)
            SFS_OOF_2OF4: win = SFS_WIN4;
            SFS_OOF_2OF5: win = SFS_WIN5;
            SFS_OOF_2OF6: win = SFS_WIN6;
            default: win = SFS_WIN1;
        endcase
    end

    // ***********************************
    // search, confirm and monitor
    // ***********************************
    // only the super-frame search lives here, whichever mode j1_mode_in
    // picks; the multiplexer and SLC-96 searches have no J1 form
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ferr = 1'b0;
        nxt_r.oof_ev = 1'b0;
        word = '0;
        slip = 1'b0;
        mimic_now = 1'b0;
        bad = 1'b0;
        take = rx_valid_in && fifo_in_ready;
        is_f = r_ff.bit_cnt == SFS_FBIT_POS;
        nf = next_frame(r_ff.frame);
        cur_frame = is_f ? nf : r_ff.frame;
        new_fsr = {r_ff.fsr[10:0], rx_bit_in};
        new_msr = {r_ff.msr[10:0], rx_bit_in};
        new_errs = r_ff.errs;
        word.data = rx_bit_in;
        if (take && !framer_bypass_in) begin
            // one probe slot per search pass keeps this free of a
            // 193-deep history; a mimic elsewhere may go unseen
            if (r_ff.st != SFS_SYNC && !is_f &&
                r_ff.bit_cnt == r_ff.mpos) begin
                nxt_r.msr = new_msr;
                if (r_ff.mcnt != SFS_MIMIC_FULL) begin
                    nxt_r.mcnt = r_ff.mcnt + 4'h1;
                end else begin
                    mimic_now = fas_match(new_msr, j1_mode_in);
                end
            end
            if (mimic_now) begin
                nxt_r.mimic_hit = 1'b1;
            end
            if (is_f) begin
                unique case (r_ff.st)
                    SFS_HUNT: begin
                        nxt_r.fsr = new_fsr;
                        nxt_r.hcnt = r_ff.hcnt + SFS_HUNT_ONE;
                        if (r_ff.hcnt >= SFS_HUNT_FULL &&
                            fas_match(new_fsr, j1_mode_in)) begin
                            nxt_r.st = SFS_CONFIRM;
                            nxt_r.frame = SFS_LAST_FRAME;
                            nxt_r.mimic_hit = mimic_now;
                        end else if (r_ff.hcnt >= SFS_HUNT_LIMIT) begin
                            slip = 1'b1;
                        end
                    end
                    SFS_CONFIRM: begin
                        nxt_r.frame = nf;
                        if (!fbit_ok(rx_bit_in, nf, j1_mode_in)) begin
                            slip = 1'b1;
                            nxt_r.st = SFS_HUNT;
                        end else if (nf == SFS_LAST_FRAME) begin
                            if (mimic_check_select_in &&
                                (r_ff.mimic_hit || mimic_now)) begin
                                slip = 1'b1;
                                nxt_r.st = SFS_HUNT;
                            end else begin
                                nxt_r.st = SFS_SYNC;
                                nxt_r.errs = '0;
                            end
                        end
                    end
                    SFS_SYNC: begin
                        nxt_r.frame = nf;
                        bad = !fbit_ok(rx_bit_in, nf, j1_mode_in);
                        nxt_r.ferr = bad;
                        new_errs = {r_ff.errs[4:0], bad};
                        nxt_r.errs = new_errs;
                        if (ones6(new_errs & win) >= ((win == SFS_WIN1) ?
                            SFS_ONE_ERR : SFS_OOF_ERRS)) begin
                            nxt_r.oof_ev = 1'b1;
                            nxt_r.st = SFS_HUNT;
                            slip = 1'b1;
                        end
                    end
                    default: begin
                        nxt_r.st = SFS_HUNT;
                        slip = 1'b1;
                    end
                endcase
            end
            if (r_ff.st == SFS_SYNC && !nxt_r.oof_ev) begin
                word.mf_start = is_f && nf == SFS_FIRST_FRAME;
                word.terminal_fbit = is_f && nf[0];
                word.signaling_fbit = is_f && !nf[0];
                word.sig_a = !is_f &&
                    r_ff.bit_cnt[2:0] == SFS_CH_BIT8 &&
                    cur_frame == SFS_SIG_A_FRAME;
                word.sig_b = !is_f &&
                    r_ff.bit_cnt[2:0] == SFS_CH_BIT8 &&
                    cur_frame == SFS_SIG_B_FRAME;
            end
            // holding the counter at the framing slot moves the
            // candidate one bit later; this is how a search restarts
            if (slip) begin
                nxt_r.bit_cnt = SFS_FBIT_POS;
                nxt_r.hcnt = '0;
                nxt_r.fsr = '0;
                nxt_r.msr = '0;
                nxt_r.mcnt = '0;
                nxt_r.mimic_hit = 1'b0;
                nxt_r.mpos = (r_ff.mpos == SFS_LAST_BIT) ?
                    SFS_MIMIC_FIRST : r_ff.mpos + SFS_ONE_BIT;
            end else if (r_ff.bit_cnt == SFS_LAST_BIT) begin
                nxt_r.bit_cnt = SFS_FBIT_POS;
            end else begin
                nxt_r.bit_cnt = r_ff.bit_cnt + SFS_ONE_BIT;
            end
        end
        // a mimic in the clearing cycle keeps the flag set
        if (mimic_now) begin
            nxt_r.mimic_flag = 1'b1;
        end else if (mimic_clear_in) begin
            nxt_r.mimic_flag = 1'b0;
        end
        nxt_r.oof = nxt_r.st != SFS_SYNC;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            r_ff <= '{st: SFS_HUNT, bit_cnt: SFS_FBIT_POS,
                      frame: SFS_LAST_FRAME, fsr: 12'h000, hcnt: 5'h00,
                      msr: 12'h000, mcnt: 4'h0, mpos: SFS_MIMIC_FIRST,
                      mimic_hit: 1'b0, errs: 6'h00, mimic_flag: 1'b0,
                      oof: 1'b1, ferr: 1'b0, oof_ev: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ***********************************
    // output buffer
    // ***********************************
    // a full buffer stalls the line side through rx_ready_out
    sfs_fifo #(
        .W(SFS_WORD_W),
        .DEPTH(SFS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(rx_valid_in),
        .in_ready_out(fifo_in_ready),
        .in_data_in(word),
        .out_valid_out(out_valid_out),
        .out_ready_in(out_ready_in),
        .out_data_out(out_word_out)
    );

    assign rx_ready_out = fifo_in_ready;
    assign out_of_frame_status_out = r_ff.oof;
    assign mimic_seen_flag_out = r_ff.mimic_flag;
    assign framing_error_out = r_ff.ferr;
    assign oof_event_out = r_ff.oof_ev;

endmodule
`default_nettype wire

// File: sfs_pkg.sv
package sfs_pkg;

    // ***********************************
    // super-frame geometry
    // ***********************************
    localparam logic [7:0] SFS_FBIT_POS = 8'h00;
    localparam logic [7:0] SFS_LAST_BIT = 8'hc0;
    localparam logic [2:0] SFS_CH_BIT8 = 3'h0;
    localparam logic [3:0] SFS_FIRST_FRAME = 4'h1;
    localparam logic [3:0] SFS_LAST_FRAME = 4'hc;
    localparam logic [3:0] SFS_SIG_A_FRAME = 4'h6;
    localparam logic [3:0] SFS_SIG_B_FRAME = 4'hc;
    localparam logic [3:0] SFS_ONE_FRAME = 4'h1;
    localparam logic [7:0] SFS_ONE_BIT = 8'h01;

    // ***********************************
    // alignment sequence, frame 1 in bit 11
    // ***********************************
    localparam logic [11:0] SFS_ALIGN_SEQ = 12'h8dc;
    localparam logic [11:0] SFS_T1_MASK = 12'hfff;
    localparam logic [11:0] SFS_J1_MASK = 12'hffe;

    // ***********************************
    // search and loss criteria
    // ***********************************
    localparam logic [4:0] SFS_HUNT_FULL = 5'h0b;
    localparam logic [4:0] SFS_HUNT_LIMIT = 5'h16;
    localparam logic [4:0] SFS_HUNT_ONE = 5'h01;
    localparam logic [3:0] SFS_MIMIC_FULL = 4'hb;
    localparam logic [7:0] SFS_MIMIC_FIRST = 8'h01;
    localparam logic [1:0] SFS_OOF_2OF4 = 2'h0;
    localparam logic [1:0] SFS_OOF_2OF5 = 2'h1;
    localparam logic [1:0] SFS_OOF_2OF6 = 2'h2;
    localparam logic [5:0] SFS_WIN4 = 6'h0f;
    localparam logic [5:0] SFS_WIN5 = 6'h1f;
    localparam logic [5:0] SFS_WIN6 = 6'h3f;
    localparam logic [5:0] SFS_WIN1 = 6'h01;
    localparam logic [2:0] SFS_OOF_ERRS = 3'h2;
    localparam logic [2:0] SFS_ONE_ERR = 3'h1;

    localparam int SFS_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        SFS_HUNT,
        SFS_CONFIRM,
        SFS_SYNC
    } sfs_state_e;

    typedef struct packed {
        logic data;
        logic mf_start;
        logic terminal_fbit;
        logic signaling_fbit;
        logic sig_a;
        logic sig_b;
    } sfs_word_s;

    localparam int SFS_WORD_W = $bits(sfs_word_s);

endpackage

// File: sfs_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sfs_fifo_s;

    sfs_fifo_s r_ff;
    sfs_fifo_s nxt_r;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = r_ff.wp == r_ff.rp;
    assign full = (r_ff.wp[AW-1:0] == r_ff.rp[AW-1:0]) &&
                  (r_ff.wp[AW] != r_ff.rp[AW]);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = r_ff.mem[r_ff.rp[AW-1:0]];

    always_comb begin
        nxt_r = r_ff;
        if (in_valid_in && !full) begin
            nxt_r.mem[r_ff.wp[AW-1:0]] = in_data_in;
            nxt_r.wp = r_ff.wp + PTR_ONE;
        end
        if (out_ready_in && !empty) begin
            nxt_r.rp = r_ff.rp + PTR_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

endmodule
`default_nettype wire

// File: sfs_line_src.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_line_src
    import sfs_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic run_in,
    input wire logic ready_in,
    input wire logic yellow_in,
    input wire logic mimic_in,
    input wire logic ferr_in,
    output logic bit_out,
    output logic valid_out
);
    int n = 0;
    int seed = 5;
    logic took = 1'b0;
    logic b;
    initial valid_out = 1'b0;
    initial bit_out = 1'b0;
    always @(posedge clk_in) took <= valid_out && ready_in && !srst_in;
    always @(negedge clk_in) begin
        n = srst_in ? 0 : n + int'(took);
        b = SFS_ALIGN_SEQ[11 - (n / 193) % 12];
        if (n % 193 == 0) begin
            b = (b | (yellow_in && n % 2316 == 2123)) ^ ferr_in;
        end else if (n % 193 == 1) begin
            b = b & mimic_in;
        end else begin
            b = 1'($random(seed));
        end
        // offered bit held until taken; idle line toggles, never parks
        if (srst_in || took || !valid_out) begin
            valid_out = run_in && !srst_in && ($random(seed) & 7) != 0;
            bit_out = valid_out ? b : ~bit_out;
        end
    end
endmodule
`default_nettype wire

// File: sfs_frame_sync_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_frame_sync_asserts
    import sfs_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic rx_valid_in,
    input wire logic rx_ready_out,
    input wire logic framer_bypass_in,
    input wire logic mimic_clear_in,
    input wire logic out_valid_out,
    input wire sfs_word_s out_word_out,
    input wire logic out_of_frame_status_out,
    input wire logic mimic_seen_flag_out,
    input wire logic framing_error_out,
    input wire logic oof_event_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_loss;
        !out_of_frame_status_out ##1 oof_event_out;
    endsequence
    sequence s_take;
        rx_valid_in && rx_ready_out;
    endsequence
    loss_sets_a:
        assert property (s_loss |-> out_of_frame_status_out)
        else $error("loss event left status clear");
    oof_cause_a:
        assert property ($rose(out_of_frame_status_out) |-> oof_event_out)
        else $error("status rose without loss event");
    err_in_sync_a:
        assert property (framing_error_out |-> !$past(out_of_frame_status_out))
        else $error("framing error outside sync");
    bypass_freeze_a:
        assert property (framer_bypass_in |=>
            $stable(out_of_frame_status_out) && !oof_event_out)
        else $error("framer moved in bypass");
    mimic_sticky_a:
        assert property (mimic_seen_flag_out && !mimic_clear_in |=>
            mimic_seen_flag_out)
        else $error("mimic flag dropped");
    bit_lands_a:
        assert property (s_take |=> out_valid_out)
        else $error("taken bit not offered");
    full_only_a:
        assert property (!rx_ready_out |-> out_valid_out)
        else $error("refusing while empty");
    mf_mark_a:
        assert property (out_valid_out && out_word_out.mf_start |->
            out_word_out.terminal_fbit && !out_word_out.signaling_fbit)
        else $error("multiframe start not on terminal bit");
endmodule
`default_nettype wire

// File: sfs_frame_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_frame_sync_tb
    import sfs_pkg::*;
;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic run = 1'b0, yel = 1'b0, mim = 1'b0, ferr = 1'b0, j1 = 1'b0;
    logic mchk = 1'b0, byp = 1'b0, mclr = 1'b0, ordy = 1'b0, hold = 1'b1;
    logic [1:0] crit = 2'h0;
    logic rbit, rvld, rrdy, ovld, oofs, mflag, fe_p, oofe;
    sfs_word_s word, w;
    int seed = 5;
    int mismatches = 0;
    int comparisons = 0;
    int nin = 0, nout = 0, bad = 0, bad_at = -1, mk = 0, nfe = 0;
    logic q[$];

    always #10 clk_in = ~clk_in;

    sfs_frame_sync DUT (
        .clk_in(clk_in), .srst_in(srst_in), .rx_bit_in(rbit),
        .rx_valid_in(rvld), .rx_ready_out(rrdy), .j1_mode_in(j1),
        .mimic_check_select_in(mchk), .framer_bypass_in(byp),
        .oof_criteria_in(crit), .mimic_clear_in(mclr),
        .out_valid_out(ovld), .out_ready_in(ordy), .out_word_out(word),
        .out_of_frame_status_out(oofs), .mimic_seen_flag_out(mflag),
        .framing_error_out(fe_p), .oof_event_out(oofe)
    );
    sfs_line_src u_src (
        .clk_in(clk_in), .srst_in(srst_in), .run_in(run), .ready_in(rrdy),
        .yellow_in(yel), .mimic_in(mim), .ferr_in(ferr), .bit_out(rbit),
        .valid_out(rvld)
    );

    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        comparisons++;
        if (e !== g) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    // marks only once sync lands on the 24th framing bit
    function automatic sfs_word_s exp_word(int n, logic b);
        sfs_word_s e;
        int s;
        int f;
        logic on;
        s = n % 193;
        f = (n / 193) % 12 + 1;
        on = mk == 1 && n > 23 * 193;
        e.data = b;
        e.mf_start = on && s == 0 && f == 1;
        e.terminal_fbit = on && s == 0 && f % 2 == 1;
        e.signaling_fbit = on && s == 0 && f % 2 == 0;
        e.sig_a = on && s != 0 && s % 8 == 0 && f == 6;
        e.sig_b = on && s != 0 && s % 8 == 0 && f == 12;
        return e;
    endfunction

    always @(negedge clk_in) ordy <= !hold && ($random(seed) & 7) != 0;

    always @(posedge clk_in) begin
        if (srst_in) begin
            q.delete();
            nin = 0;
            nout = 0;
        end else begin
            if (oofe && bad_at < 0) begin
                bad_at = bad;
            end
            if (fe_p) begin
                nfe++;
            end
            if (rvld && rrdy) begin
                if (nin % 193 == 0 &&
                    rbit !== SFS_ALIGN_SEQ[11 - (nin / 193) % 12]) begin
                    bad++;
                end
                q.push_back(rbit);
                nin++;
            end
            if (ovld && ordy) begin
                w = exp_word(nout, q.pop_front());
                if (mk == 2) begin
                    check("data", 8'(w.data), 8'(word.data));
                end else begin
                    check("word", 8'(w), 8'(word));
                end
                nout++;
            end
        end
    end

    task automatic run_case(input string name, input int m, input int fe);
        @(negedge clk_in);
        srst_in = 1'b1;
        run = 1'b0;
        hold = 1'b1;
        ferr = 1'b0;
        mk = m;
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        run = 1'b1;
        bad_at = -1;
        repeat (12) @(negedge clk_in);
        check("ready when full", 8'h00, 8'(rrdy));
        hold = 1'b0;
        while (nin < 28 * 193) begin
            @(negedge clk_in);
            if (fe > 0 && nin >= fe * 193 && !ferr) begin
                ferr = 1'b1;
                bad = 0;
                nfe = 0;
            end
        end
        run = 1'b0;
        repeat (20) @(negedge clk_in);
        check("drained", 8'h00, 8'(ovld));
        $display("test %s done", name);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        run_case("t1 clean", 1, 0);
        check("oof", 8'h00, 8'(oofs));
        check("mimic idle", 8'h00, 8'(mflag));
        yel = 1'b1;
        for (int i = 0; i < 2; i++) begin
            j1 = i[0];
            run_case("yellow", i, 0);
            check("oof yellow", 8'(!j1), 8'(oofs));
        end
        {yel, j1, mim} = 3'h1;
        for (int i = 0; i < 2; i++) begin
            mchk = i[0];
            run_case("mimic", 1 - i, 0);
            check("oof mimic", 8'(mchk), 8'(oofs));
            check("mimic seen", 8'h01, 8'(mflag));
            mclr = 1'b1;
            @(negedge clk_in);
            mclr = 1'b0;
            @(negedge clk_in);
            check("mimic clear", 8'h00, 8'(mflag));
        end
        {mim, mchk, byp} = 3'h1;
        run_case("bypass", 0, 0);
        check("oof bypass", 8'h01, 8'(oofs));
        byp = 1'b0;
        for (int i = 0; i < 4; i++) begin
            crit = i[1:0];
            run_case("loss", 2, 25);
            check("loss point", (crit == 2'h3) ? 8'h01 : 8'h02,
                  8'(bad_at));
            check("oof after loss", 8'h01, 8'(oofs));
            check("ferr pulses", (crit == 2'h3) ? 8'h01 : 8'h02,
                  8'(nfe));
        end
        report_and_stop();
    end

    // ten cases of roughly sixty-five hundred cycles each, with margin
    initial begin
        repeat (90000) @(posedge clk_in);
        mismatches++;
        report_and_stop();
    end
endmodule

bind sfs_frame_sync sfs_frame_sync_asserts u_chk (
    .clk_in(clk_in), .srst_in(srst_in), .rx_valid_in(rx_valid_in),
    .rx_ready_out(rx_ready_out), .framer_bypass_in(framer_bypass_in),
    .mimic_clear_in(mimic_clear_in), .out_valid_out(out_valid_out),
    .out_word_out(out_word_out),
    .out_of_frame_status_out(out_of_frame_status_out),
    .mimic_seen_flag_out(mimic_seen_flag_out),
    .framing_error_out(framing_error_out), .oof_event_out(oof_event_out)
);
`default_nettype wire
